/* File: core/cfg_loader_pkg.sv */
// constants, types and carriers shared by the configuration loader
// assumes a single 10 MHz system clock and pin-level signals from outside
//
// Operation
// - master serial chain output lags 1.5 config_clock periods, changing on falling edge.
// - with eightfold_clock_rate, generated clock speeds up eightfold after a few bits.
// - mode pins 000 select master serial.
// - slave serial samples data on rising edge, updates chain output on falling edge.
// - mode pins 111 select slave serial, the default with pull-ups.
// - master parallel latches byte and steps address together; bit0 out 1.5 periods later.
// - mode 100 is master parallel up, address from 00000 incrementing.
// - mode 110 is master parallel down, address from 3FFFF decrementing.
// - first byte loads and clock starts at end of first rom_read_clock cycle.
// - synchronous peripheral captures on second rising edge, then every eighth.
// - synchronous peripheral handshake high for exactly one period from capture edge.
// - handshake undriven (pulled high) before clear_complete_pin goes high.
// - mode pins 011 select synchronous peripheral.
// - asynchronous capture at trailing edge of the write select condition.
// - captured byte goes through input buffer then shift register.
// - asynchronous handshake low on receipt, high once buffer moved into shift register.
// - busy lasts two periods if shifter empty, up to nine if full.
// - preamble and overflow data forwarded on serial_data_out in every mode.
// - mode pins 101 select asynchronous peripheral.
// - status read drives bit 7 ready/busy, bits 0 to 6 high.

package cfg_loader_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 32'h64;   // 100 ns system clock
	localparam int SLOW_CONFIG_CLOCK_NS  = 32'h640;  // 1600 ns, 625 kHz
	localparam int FAST_CONFIG_CLOCK_NS  = 32'hC8;   // 200 ns, 5 MHz
	localparam int SLOW_HALF     = SLOW_CONFIG_CLOCK_NS / (2 * CLK_PERIOD_NS);
	localparam int FAST_HALF     = FAST_CONFIG_CLOCK_NS / (2 * CLK_PERIOD_NS);
	localparam int FAST_AFTER_BITS = 32'h10; // bits before the rate switch
	localparam int CONFIG_BITS   = 32'h1000; // own configuration size

	// ****************************************
	// mode codes and start values
	// ****************************************
	localparam logic [2:0] MODE_MSER = 3'h0;
	localparam logic [2:0] MODE_SSER = 3'h7;
	localparam logic [2:0] MODE_MPUP = 3'h4;
	localparam logic [2:0] MODE_MPDN = 3'h6;
	localparam logic [2:0] MODE_SPER = 3'h3;
	localparam logic [2:0] MODE_APER = 3'h5;
	localparam logic [17:0] ADDR_UP_START = 18'h00000;
	localparam logic [17:0] ADDR_DN_START = 18'h3FFFF;
	localparam logic [2:0] PHASE_ROM     = 3'h6;  // rom clock high / first rise
	localparam logic [2:0] PHASE_CAPTURE = 3'h7;  // byte capture rise
	localparam logic [6:0] STATUS_FILL   = 7'h7F;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOAD = 2'h1,
		ST_DONE = 2'h2
	} load_state_t;

	typedef struct packed {
		logic write_strobe_b;
		logic chip_select_low_b;
		logic chip_select_high;
		logic read_status_select_b;
	} periph_ctl_t;

endpackage

/* File: core/config_bitstream_loader.sv */
// configuration loader: five load modes, byte serialiser, chain output
// assumes pins arrive asynchronously and are synchronised here; one 10 MHz clock
//
`timescale 1ns/1ps
`default_nettype none

module config_bitstream_loader #(
	parameter int CONFIG_BITS = cfg_loader_pkg::CONFIG_BITS,
	parameter int FAST_AFTER  = cfg_loader_pkg::FAST_AFTER_BITS
) (
	// clock and reset
	input  wire logic                        i_clk_sys,
	input  wire logic                        i_rst_b,
	// mode and control pins
	input  wire logic                        i_mode_select_bit2,
	input  wire logic                        i_mode_select_bit1,
	input  wire logic                        i_mode_select_bit0,
	input  wire logic                        i_eightfold_clock_rate,
	input  wire logic                        i_clear_complete,
	input  wire logic                        i_done_line,
	// serial link
	input  wire logic                        i_config_clock,
	output logic                             o_config_clock,
	output logic                             o_config_clock_oe,
	input  wire logic                        i_serial_data_in,
	output logic                             o_serial_data_out,
	// prom addressing
	output logic [17:0]                      o_prom_address,
	output logic                             o_rom_read_clock,
	// peripheral bus
	input  wire cfg_loader_pkg::periph_ctl_t i_periph,
	input  wire logic [7:0]                  i_data,
	output logic [7:0]                       o_data,
	output logic                             o_data_oe,
	output logic                             o_handshake_flag,
	output logic                             o_handshake_flag_oe,
	// internal configuration side
	output logic                             o_config_bit,
	output logic                             o_config_bit_valid,
	output logic                             o_low_during_config,
	output logic                             o_config_done
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	localparam int PW = 19;
	logic [PW-1:0] pin_s1;
	logic [PW-1:0] pin_s2;
	logic [9:0]    pin_s3;   // clock, data in, data bus: one stage more
	logic          config_clock_prev;
	wire  [PW-1:0] pin_raw = {i_mode_select_bit2, i_mode_select_bit1, i_mode_select_bit0,
		i_clear_complete, i_done_line, i_periph, i_config_clock, i_serial_data_in, i_data};

	// two flops before any logic; the third aligns data with the clock edge detect
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			pin_s1    <= '0;
			pin_s2    <= '0;
			pin_s3    <= '0;
			config_clock_prev <= 1'b0;
		end
		else
		begin
			pin_s1    <= pin_raw;
			pin_s2    <= pin_s1;
			pin_s3    <= pin_s2[9:0];
			config_clock_prev <= pin_s3[9];
		end
	end

	wire [2:0] mode_pins  = pin_s2[18:16];
	wire       init_s     = pin_s2[15];
	wire       done_s     = pin_s2[14];
	cfg_loader_pkg::periph_ctl_t pc;
	assign pc = pin_s2[13:10];
	wire [7:0] data_m     = pin_s2[7:0];   // master modes: own clock, no edge lag
	wire [7:0] data_x     = pin_s3[7:0];   // slave and async paths
	wire       din_m      = pin_s2[8];
	wire       din_x      = pin_s3[8];
	wire       ext_rise   = pin_s3[9] & ~config_clock_prev;
	wire       ext_fall   = ~pin_s3[9] & config_clock_prev;

	// ****************************************
	// state and mode decode
	// ****************************************
	cfg_loader_pkg::load_state_t state;
	logic [2:0] mode;
	wire loading = (state == cfg_loader_pkg::ST_LOAD);
	wire is_mser = (mode == cfg_loader_pkg::MODE_MSER);
	wire is_sser = (mode == cfg_loader_pkg::MODE_SSER);
	wire is_mpup = (mode == cfg_loader_pkg::MODE_MPUP);
	wire is_mpdn = (mode == cfg_loader_pkg::MODE_MPDN);
	wire is_sper = (mode == cfg_loader_pkg::MODE_SPER);
	wire is_aper = (mode == cfg_loader_pkg::MODE_APER);
	wire is_mpar = is_mpup | is_mpdn;
	wire is_ser  = is_mser | is_sser;
	wire is_mclk = is_mser | is_mpar | is_aper;

	// mode is caught when clear_complete releases; undefined codes are latched unchanged and match no mode decode
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state <= cfg_loader_pkg::ST_IDLE;
			mode  <= cfg_loader_pkg::MODE_SSER;
		end
		else
		begin
			unique case (state)
				cfg_loader_pkg::ST_IDLE:
				begin
					if (init_s)
					begin
						state <= cfg_loader_pkg::ST_LOAD;
						mode  <= mode_pins;
					end
				end
				cfg_loader_pkg::ST_LOAD:
					if (done_s) state <= cfg_loader_pkg::ST_DONE;
				cfg_loader_pkg::ST_DONE:
					if (!init_s) state <= cfg_loader_pkg::ST_IDLE;
				default:
					state <= cfg_loader_pkg::ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// config clock generator
	// ****************************************
	logic       fast;
	logic [3:0] gen_cnt;
	logic       gen_clk;
	logic       clk_started;
	wire  [3:0] half      = fast ? 4'(cfg_loader_pkg::FAST_HALF) : 4'(cfg_loader_pkg::SLOW_HALF);
	wire        gen_run   = loading & is_mclk;
	wire        gen_tick  = gen_run & (gen_cnt >= half - 4'h1);
	wire        gen_rise  = gen_tick & ~gen_clk;
	wire        gen_fall  = gen_tick & gen_clk;
	wire        rise      = is_mclk ? gen_rise : (loading & ext_rise);
	wire        fall      = is_mclk ? gen_fall : (loading & ext_fall);

	// the divider keeps counting when the rate changes, so a half period in progress can be cut short
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			gen_cnt <= 4'h0;
			gen_clk <= 1'b0;
		end
		else if (!gen_run)
		begin
			gen_cnt <= 4'h0;
			gen_clk <= 1'b0;
		end
		else if (gen_tick)
		begin
			gen_cnt <= 4'h0;
			gen_clk <= ~gen_clk;
		end
		else
			gen_cnt <= gen_cnt + 4'h1;
	end

	// output clock held low in master parallel until the first capture edge starts it
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_config_clock    <= 1'b0;
			o_config_clock_oe <= 1'b0;
		end
		else
		begin
			o_config_clock    <= (gen_tick ? ~gen_clk : gen_clk) & gen_run
				& (~is_mpar | clk_started | cap_sync);
			o_config_clock_oe <= gen_run;
		end
	end

	// ****************************************
	// byte capture: parallel modes and async writes
	// ****************************************
	logic [2:0] phase;
	logic       wr_prev;
	logic [7:0] buf_byte;
	logic       buf_full;
	logic [6:0] shifter;
	logic [3:0] sh_cnt;
	wire        wr_cond  = ~pc.write_strobe_b & ~pc.chip_select_low_b
		& pc.read_status_select_b & pc.chip_select_high;
	wire        rd_cond  = pc.write_strobe_b & ~pc.chip_select_low_b
		& ~pc.read_status_select_b & pc.chip_select_high;
	wire        cap_sync = rise & (is_mpar | is_sper) & (phase == cfg_loader_pkg::PHASE_CAPTURE);
	wire        cap_asyn = loading & is_aper & wr_prev & ~wr_cond & ~buf_full;
	wire        cap      = cap_sync | cap_asyn;
	wire [7:0]  cap_data = is_mpar ? data_m : data_x;
	wire        move     = rise & ~is_ser & buf_full & (sh_cnt == 4'h0);

	// capture on second rise, then every eighth; address steps on the same edge
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			phase            <= cfg_loader_pkg::PHASE_ROM;
			wr_prev          <= 1'b0;
			o_prom_address   <= cfg_loader_pkg::ADDR_UP_START;
			o_rom_read_clock <= 1'b0;
			clk_started      <= 1'b0;
		end
		else if (!loading)
		begin
			phase            <= cfg_loader_pkg::PHASE_ROM;
			wr_prev          <= 1'b0;
			// pins, not the latched mode: the start address must stand when loading begins
			o_prom_address   <= (mode_pins == cfg_loader_pkg::MODE_MPDN)
				? cfg_loader_pkg::ADDR_DN_START
				: cfg_loader_pkg::ADDR_UP_START;
			o_rom_read_clock <= 1'b0;
			clk_started      <= 1'b0;
		end
		else
		begin
			wr_prev <= wr_cond;
			if (rise)
			begin
				phase            <= phase + 3'h1;
				o_rom_read_clock <= is_mpar & (phase == cfg_loader_pkg::PHASE_ROM);
			end
			if (cap_sync & is_mpar)
			begin
				clk_started    <= 1'b1;
				o_prom_address <= is_mpup ? o_prom_address + 18'h1
					: o_prom_address - 18'h1;
			end
		end
	end

	// double buffer: input byte waits until the shifter has emptied
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			buf_byte <= 8'h00;
			buf_full <= 1'b0;
			shifter  <= 7'h00;
			sh_cnt   <= 4'h0;
		end
		else if (!loading)
		begin
			buf_full <= 1'b0;
			sh_cnt   <= 4'h0;
		end
		else
		begin
			if (cap)
			begin
				buf_byte <= cap_data;
				buf_full <= 1'b1;
			end
			else if (move)
				buf_full <= 1'b0;
			if (move)
			begin
				shifter <= buf_byte[7:1];
				sh_cnt  <= 4'h7;
			end
			else if (rise & (sh_cnt != 4'h0))
			begin
				shifter <= {1'b0, shifter[6:1]};
				sh_cnt  <= sh_cnt - 4'h1;
			end
		end
	end

	// ****************************************
	// bit stream: internal logic and chain output
	// ****************************************
	logic        pend;
	logic        pend_v;
	logic [31:0] bits;
	wire         bit_now  = is_ser ? (is_mser ? din_m : din_x) : (move ? buf_byte[0] : shifter[0]);
	wire         has_bit  = rise & (is_ser | move | (sh_cnt != 4'h0));
	wire         mem_full = (bits >= 32'(CONFIG_BITS));

	// bit taken at a rise is shown downstream on the following fall
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			pend              <= 1'b0;
			pend_v            <= 1'b0;
			o_serial_data_out <= 1'b1;
		end
		else
		begin
			if (rise)
			begin
				pend   <= bit_now;
				pend_v <= has_bit;
			end
			if (fall & pend_v)
				o_serial_data_out <= pend;
		end
	end

	// own memory takes bits until full; the rate switch counts from the first bit
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			bits               <= 32'h0;
			fast               <= 1'b0;
			o_config_bit       <= 1'b0;
			o_config_bit_valid <= 1'b0;
			o_config_done      <= 1'b0;
		end
		else if (!loading)
		begin
			bits               <= (state == cfg_loader_pkg::ST_DONE) ? bits : 32'h0;
			fast               <= 1'b0;
			o_config_bit_valid <= 1'b0;
			o_config_done      <= (state == cfg_loader_pkg::ST_DONE) & mem_full;
		end
		else
		begin
			o_config_bit       <= bit_now;
			o_config_bit_valid <= has_bit & ~mem_full;
			if (has_bit & ~mem_full)
				bits <= bits + 32'h1;
			fast          <= i_eightfold_clock_rate & (bits >= 32'(FAST_AFTER));
			o_config_done <= mem_full;
		end
	end

	// ****************************************
	// handshake and status read
	// ****************************************
	logic wait_ready;

	// async: low on receipt, high one rise after the byte moved on
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_handshake_flag    <= 1'b1;
			o_handshake_flag_oe <= 1'b0;
			wait_ready          <= 1'b0;
		end
		else if (!loading)
		begin
			o_handshake_flag    <= 1'b1;
			o_handshake_flag_oe <= 1'b0;
			wait_ready          <= 1'b0;
		end
		else
		begin
			o_handshake_flag_oe <= is_sper | is_aper;
			if (is_sper)
			begin
				if (rise)
					o_handshake_flag <= cap_sync;
			end
			else if (cap_asyn)
			begin
				o_handshake_flag <= 1'b0;
				wait_ready       <= 1'b0;
			end
			else if (move)
				wait_ready <= 1'b1;
			else if (rise & wait_ready)
			begin
				o_handshake_flag <= 1'b1;
				wait_ready       <= 1'b0;
			end
		end
	end

	// status read puts ready on bit 7, ones below
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_data              <= 8'hFF;
			o_data_oe           <= 1'b0;
			o_low_during_config <= 1'b0;
		end
		else
		begin
			o_data    <= {o_handshake_flag, cfg_loader_pkg::STATUS_FILL};
			o_data_oe <= loading & is_aper & rd_cond;
			o_low_during_config <= (state == cfg_loader_pkg::ST_DONE);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_sync_capture;
		loading & is_sper & cap_sync;
	endsequence

	sequence s_async_empty_capture;
		cap_asyn & (sh_cnt == 4'h0) & ~fast;
	endsequence

	// check helper: armed by a sync capture, cleared by the next rise
	logic ack_armed;
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			ack_armed <= 1'b0;
		else if (rise)
			ack_armed <= cap_sync & is_sper & loading;
	end

	a_ack_one_period: assert property (s_sync_capture |=> o_handshake_flag until rise)
		else $error("sync ack dropped before next edge");
	a_ack_ends: assert property (ack_armed & rise |=> !o_handshake_flag)
		else $error("sync ack longer than one period");
	a_flag_undriven: assert property (state == cfg_loader_pkg::ST_IDLE |=> !o_handshake_flag_oe)
		else $error("handshake driven before release");
	a_addr_up: assert property (cap_sync & is_mpup |=> o_prom_address == $past(o_prom_address) + 18'h1)
		else $error("address did not increment");
	a_addr_down: assert property (cap_sync & is_mpdn |=> o_prom_address == $past(o_prom_address) - 18'h1)
		else $error("address did not decrement");
	a_busy_short: assert property (s_async_empty_capture |=> !o_handshake_flag ##[1:40] o_handshake_flag)
		else $error("busy longer than two periods");
	a_chain_fall: assert property (fall & pend_v |=> o_serial_data_out == $past(pend))
		else $error("chain output missed falling edge");
	a_status_bits: assert property (o_data_oe |-> o_data == {$past(o_handshake_flag), 7'h7F})
		else $error("status byte wrong");
	a_first_byte: assert property (loading & is_mpar & rise & o_rom_read_clock |-> cap_sync)
		else $error("first byte not loaded after rom clock");

endmodule

`default_nettype wire

/* File: verif/prom_partner.sv */
// serial and byte-wide prom model facing the loader's master modes
// assumes address, enable and generated clock come straight from the loader
`timescale 1ns/1ps
`default_nettype none

module prom_partner (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	// loader side
	input  wire logic        i_config_clock,
	input  wire logic        i_enable_b,
	input  wire logic [17:0] i_prom_address,
	input  wire logic [31:0] i_pattern,
	// data back to the loader
	output logic [7:0]       o_byte,
	output logic             o_serial_bit
);
	logic       clock_seen;
	logic [4:0] bit_index;
	logic [7:0] last_byte;
	logic       last_bit;

	// ****************************************
	// serial pointer
	// ****************************************
	// steps one edge after the rise, so the loader still samples the old bit
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			clock_seen <= 1'b0;
			bit_index  <= 5'h00;
		end
		else
		begin
			clock_seen <= i_config_clock;
			if (i_config_clock && !clock_seen)
				bit_index <= bit_index + 5'h01;
		end
	end

	// released outputs show the inverse of the last value, never a stale copy
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_enable_b)
		begin
			last_byte <= i_prom_address[7:0] ^ 8'hA5;
			last_bit  <= i_pattern[bit_index];
		end
	end
	assign o_byte       = i_enable_b ? ~last_byte : (i_prom_address[7:0] ^ 8'hA5);
	assign o_serial_bit = i_enable_b ? ~last_bit : i_pattern[bit_index];

endmodule

`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the configuration loader, all five load modes
// assumes the prom partner model and a pulled-up handshake pin
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic                        clk_sys   = 1'b0;
	logic                        rst_b     = 1'b0;
	logic [2:0]                  mode      = 3'h7;
	logic                        fast      = 1'b0;
	logic                        clear     = 1'b0;
	logic                        link_clk  = 1'b0;
	logic                        host_bit  = 1'b0;
	logic [7:0]                  host_data = 8'h00;
	logic                        use_prom  = 1'b0;
	logic [31:0]                 pattern   = 32'h0;
	cfg_loader_pkg::periph_ctl_t periph    = 4'hD;
	logic                        config_clock_out, config_clock_oe, dout, rom_clk, hs_flag, hs_oe, low_during_config, stat_oe;
	logic                        prom_bit, hs_pin, q, h;
	logic [17:0]                 prom_addr, a0;
	logic [7:0]                  stat_data, prom_byte, b0, b1;
	logic [17:0]                 sbits;
	logic                        expq[$];
	int                          n_errors  = 0;
	int                          tests_run = 0;
	int                          rises     = 0;
	int                          k, m, n;
	time                         t0, t1;

	// ****************************************
	// clock, pins and instances
	// ****************************************
	always #50 clk_sys = ~clk_sys;
	always @(posedge config_clock_out) rises++;
	assign hs_pin = hs_oe ? hs_flag : 1'b1; // weak pull-up when undriven

	config_bitstream_loader #(.CONFIG_BITS(64), .FAST_AFTER(4)) i_config_bitstream_loader (
		.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_mode_select_bit2(mode[2]),
		.i_mode_select_bit1(mode[1]), .i_mode_select_bit0(mode[0]),
		.i_eightfold_clock_rate(fast), .i_clear_complete(clear), .i_done_line(1'b0),
		.i_config_clock(link_clk), .o_config_clock(config_clock_out), .o_config_clock_oe(config_clock_oe),
		.i_serial_data_in(use_prom ? prom_bit : host_bit), .o_serial_data_out(dout),
		.o_prom_address(prom_addr), .o_rom_read_clock(rom_clk), .i_periph(periph),
		.i_data(use_prom ? prom_byte : host_data), .o_data(stat_data), .o_data_oe(stat_oe),
		.o_handshake_flag(hs_flag), .o_handshake_flag_oe(hs_oe), .o_config_bit(),
		.o_config_bit_valid(), .o_low_during_config(low_during_config), .o_config_done());

	prom_partner i_prom_partner (
		.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_config_clock(config_clock_out), .i_enable_b(low_during_config),
		.i_prom_address(prom_addr), .i_pattern(pattern), .o_byte(prom_byte),
		.o_serial_bit(prom_bit));

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (exp !== got)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_of_test();
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// mode is latched when loading starts, so every mode needs its own reset
	task automatic restart(input logic [2:0] md, input logic f, input logic p);
		@(posedge clk_sys);
		rst_b    <= 1'b0;
		clear    <= 1'b0;
		mode     <= md;
		fast     <= f;
		use_prom <= p;
		periph   <= 4'hD;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		rises = 0;
		repeat (4) @(posedge clk_sys);
		#1 check("hs idle", 32'h1, {31'h0, hs_pin});
		check("hs oe", 32'h0, {31'h0, hs_oe});
		@(posedge clk_sys);
		clear <= 1'b1;
		repeat (6) @(posedge clk_sys);
	endtask

	// one 800 ns link period; samples just after its rise, data moves at the fall
	task automatic link_cycle(input logic s, input logic [7:0] d, output logic qs, output logic hs);
		@(posedge clk_sys);
		link_clk <= 1'b1;
		#1 qs = dout;
		hs = hs_pin;
		repeat (4) @(posedge clk_sys);
		link_clk  <= 1'b0;
		host_bit  <= s;
		host_data <= d;
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic wait_hs(input logic lvl, output int c);
		c = 0;
		while (hs_pin !== lvl && c < 400)
		begin
			@(posedge clk_sys);
			#1 c++;
		end
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		void'($urandom(27));
		pattern = $urandom();
		// slave serial: each of the first sixteen bits reappears on the chain output after the fall
		restart(cfg_loader_pkg::MODE_SSER, 1'b0, 1'b0);
		sbits = 18'($urandom());
		host_bit <= sbits[0];
		for (k = 0; k < 17; k++)
		begin
			link_cycle(sbits[k + 1], 8'h00, q, h);
			if (k > 0) check("slave out", {31'h0, sbits[k - 1]}, {31'h0, q});
		end
		// synchronous peripheral: capture on rise two, then every eighth rise
		restart(cfg_loader_pkg::MODE_SPER, 1'b0, 1'b0);
		b0 = 8'($urandom());
		b1 = 8'($urandom());
		host_data <= b0;
		for (k = 0; k < 16; k++)
			expq.push_back(k < 8 ? b0[k] : b1[k - 8]);
		for (k = 0; k < 21; k++)
		begin
			link_cycle(1'b0, (k == 0) ? b0 : b1, q, h);
			if (k == 2 || k == 10) check("ack high", 32'h1, {31'h0, h});
			if (k == 3) check("ack low", 32'h0, {31'h0, h});
			if (k >= 3 && k < 19) check("sync out", {31'h0, expq.pop_front()}, {31'h0, q});
		end
		// master parallel up then down: address start, step and bit order of the first byte
		for (m = 0; m < 2; m++)
		begin
			restart(m ? cfg_loader_pkg::MODE_MPDN : cfg_loader_pkg::MODE_MPUP, 1'b0, 1'b1);
			a0 = m ? cfg_loader_pkg::ADDR_DN_START : cfg_loader_pkg::ADDR_UP_START;
			n = 0;
			while (rom_clk !== 1'b1 && n < 100)
			begin
				@(posedge clk_sys);
				#1 n++;
			end
			check("first addr", {14'h0, a0}, {14'h0, prom_addr});
			while (prom_addr === a0 && n < 200)
			begin
				@(posedge clk_sys);
				#1 n++;
			end
			check("next addr", {14'h0, m ? a0 - 18'h1 : a0 + 18'h1}, {14'h0, prom_addr});
			b0 = a0[7:0] ^ 8'hA5;
			for (k = 0; k < 8; k++)
			begin
				@(negedge config_clock_out);
				if (k == 0)
					@(negedge config_clock_out);
				repeat (3) @(posedge clk_sys);
				#1 check("parallel out", {31'h0, b0[k]}, {31'h0, dout});
			end
		end
		// master serial at both rates; a 16-cycle period is the slow clock
		for (m = 0; m < 2; m++)
		begin
			restart(cfg_loader_pkg::MODE_MSER, m[0], 1'b1);
			#1 check("clock oe", 32'h1, {31'h0, config_clock_oe});
			for (k = 0; k < 8; k++)
			begin
				@(negedge config_clock_out);
				repeat (3) @(posedge clk_sys);
				#1 if (m == 0) check("serial out", {31'h0, pattern[(rises - 1) % 32]}, {31'h0, dout});
			end
			repeat (24) @(posedge config_clock_out);
			t0 = $time;
			@(posedge config_clock_out);
			t1 = $time;
			check("clock period", 32'(m ? 2 * cfg_loader_pkg::FAST_HALF : 2 * cfg_loader_pkg::SLOW_HALF), 32'((t1 - t0) / cfg_loader_pkg::CLK_PERIOD_NS));
		end
		// asynchronous peripheral: short busy into an empty shifter, long when full
		restart(cfg_loader_pkg::MODE_APER, 1'b0, 1'b0);
		host_data <= 8'($urandom());
		periph    <= 4'h3;
		repeat (3) @(posedge clk_sys);
		periph <= 4'hD;
		wait_hs(1'b0, n);
		check("busy start", 32'h1, {31'h0, n < 10});
		@(posedge clk_sys);
		host_data <= 8'($urandom());
		periph    <= 4'h3;
		wait_hs(1'b1, n);
		check("busy short", 32'h1, {31'h0, n >= 16 && n <= 48});
		repeat (2 * cfg_loader_pkg::SLOW_HALF) @(posedge clk_sys);
		periph <= 4'hD;
		wait_hs(1'b0, n);
		wait_hs(1'b1, n);
		check("busy long", 32'h1, {31'h0, n > 48 && n <= 160});
		@(posedge clk_sys);
		periph <= 4'hA;
		repeat (5) @(posedge clk_sys);
		#1 check("status oe", 32'h1, {31'h0, stat_oe});
		check("status byte", 32'hFF, {24'h0, stat_data});
		end_of_test();
	end

	// watchdog at 1 ms, well beyond the under two hundred microseconds the tests need
	initial
	begin
		#1_000_000;
		n_errors++;
		end_of_test();
	end

endmodule

`default_nettype wire
